// ==== include/xbp_pkg.sv ====
// Package for the external bus pin block: offsets, fields, reset values, types
package xbp_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int NUM_CS = 6;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR_AF = 8'h04;
    localparam logic [7:0] OFF_DATA_AF = 8'h08;
    localparam logic [7:0] OFF_CS_POL = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    // Control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_WIDE_BIT = 1;
    // Status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_WAIT_BIT = 1;
    // Reset values and AXI response codes
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [23:0] ADDR_AF_RST = 24'h000000;
    localparam logic [15:0] DATA_AF_RST = 16'h0000;
    localparam logic [5:0] CS_POL_RST = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Processor-side access request
    typedef struct packed {
        logic req;
        logic write;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [1:0] lanes;
        logic [2:0] cs_sel;
    } xbp_req_t;

    // Bus phase state
    typedef enum logic [2:0] {
        XBP_IDLE = 3'b001,
        XBP_READ = 3'b010,
        XBP_WRITE = 3'b100
    } xbp_phase_t;
endpackage

// ==== hw/xbp_axil_regs.sv ====
// AXI4-Lite slave holding the external bus control registers
`timescale 1ns/1ps
module xbp_axil_regs (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register contents and status
    output logic [1:0] ctrl,
    output logic [23:0] addr_af,
    output logic [15:0] data_af,
    output logic [5:0] cs_pol,
    input wire logic [1:0] status
);
    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [1:0] ctrl;
        logic [23:0] addr_af;
        logic [15:0] data_af;
        logic [5:0] cs_pol;
    } xbp_regs_st_t;

    xbp_regs_st_t st;
    xbp_regs_st_t next_st;
    logic [31:0] merged;
    logic [31:0] cur;

    assign awready = !st.aw_held && !st.bvalid;
    assign wready = !st.w_held && !st.bvalid;
    assign arready = !st.rvalid;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign rvalid = st.rvalid;
    assign rresp = st.rresp;
    assign rdata = st.rdata;
    assign ctrl = st.ctrl;
    assign addr_af = st.addr_af;
    assign data_af = st.data_af;
    assign cs_pol = st.cs_pol;

    // Channel capture, register write with byte strobes, read mux
    always_comb begin
        next_st = st;
        cur = 32'h00000000;
        merged = 32'h00000000;
        if (awvalid && awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = wdata;
            next_st.w_strb = wstrb;
        end
        if (next_st.aw_held && next_st.w_held && !st.bvalid) begin
            case (next_st.aw_addr)
                xbp_pkg::OFF_CTRL: cur = {30'h0, st.ctrl};
                xbp_pkg::OFF_ADDR_AF: cur = {8'h00, st.addr_af};
                xbp_pkg::OFF_DATA_AF: cur = {16'h0000, st.data_af};
                xbp_pkg::OFF_CS_POL: cur = {26'h0, st.cs_pol};
                default: cur = 32'h00000000;
            endcase
            for (int i = 0; i < 4; i++) begin
                merged[i*8 +: 8] = next_st.w_strb[i] ? next_st.w_data[i*8 +: 8] : cur[i*8 +: 8];
            end
            next_st.bresp = xbp_pkg::RESP_OKAY;
            case (next_st.aw_addr)
                xbp_pkg::OFF_CTRL: next_st.ctrl = merged[1:0];
                xbp_pkg::OFF_ADDR_AF: next_st.addr_af = merged[23:0];
                xbp_pkg::OFF_DATA_AF: next_st.data_af = merged[15:0];
                xbp_pkg::OFF_CS_POL: next_st.cs_pol = merged[5:0];
                default: next_st.bresp = xbp_pkg::RESP_SLVERR;
            endcase
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
        end
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = xbp_pkg::RESP_OKAY;
            case (araddr)
                xbp_pkg::OFF_CTRL: next_st.rdata = {30'h0, st.ctrl};
                xbp_pkg::OFF_ADDR_AF: next_st.rdata = {8'h00, st.addr_af};
                xbp_pkg::OFF_DATA_AF: next_st.rdata = {16'h0000, st.data_af};
                xbp_pkg::OFF_CS_POL: next_st.rdata = {26'h0, st.cs_pol};
                xbp_pkg::OFF_STATUS: next_st.rdata = {30'h0, status};
                default: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = xbp_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.ctrl <= xbp_pkg::CTRL_RST;
            st.addr_af <= xbp_pkg::ADDR_AF_RST;
            st.data_af <= xbp_pkg::DATA_AF_RST;
            st.cs_pol <= xbp_pkg::CS_POL_RST;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ==== hw/xbp_ext_bus.sv ====
// External memory bus pin logic with AXI4-Lite control registers
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module xbp_ext_bus (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Processor access port
    input wire xbp_pkg::xbp_req_t cpu_req,
    output logic cpu_stall,
    output logic cpu_done,
    output logic [15:0] cpu_rdata,
    // Internal execution indicator
    input wire logic exec_internal,
    // Address pins
    output logic [23:0] addr_out,
    output logic [23:0] addr_oe,
    // Data pins
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic [15:0] data_oe,
    // Strobes, selects and wait
    output logic read_strobe,
    output logic write_strobe,
    output logic [5:0] chip_select_out,
    output logic [5:0] chip_select_oe,
    output logic upper_byte_enable,
    output logic lower_byte_enable,
    input wire logic wait_in
);
    typedef struct packed {
        xbp_pkg::xbp_phase_t phase;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [1:0] lanes;
        logic [2:0] cs_sel;
        logic done;
        logic [15:0] rdata;
    } xbp_bus_st_t;

    xbp_bus_st_t st;
    xbp_bus_st_t next_st;
    logic [1:0] ctrl;
    logic [23:0] addr_af;
    logic [15:0] data_af;
    logic [5:0] cs_pol;
    logic enabled;
    logic wide;
    logic active;
    logic [1:0] eff_lanes;
    logic [5:0] cs_raw;
    logic [15:0] lane_mask;

    xbp_axil_regs u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .ctrl(ctrl),
        .addr_af(addr_af),
        .data_af(data_af),
        .cs_pol(cs_pol),
        .status({wait_in, active})
    );

    assign enabled = ctrl[xbp_pkg::CTRL_EN_BIT];
    assign wide = ctrl[xbp_pkg::CTRL_WIDE_BIT];
    assign active = st.phase != xbp_pkg::XBP_IDLE;
    // Narrow mode uses only the low lane
    assign eff_lanes = wide ? cpu_req.lanes : 2'b01;

    // Bus phase sequencing; wait holds the phase
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.phase)
            // A request still up while done shows is the finished one
            xbp_pkg::XBP_IDLE: begin
                if (cpu_req.req && enabled && !exec_internal && !st.done) begin
                    next_st.addr = cpu_req.addr;
                    next_st.wdata = cpu_req.wdata;
                    next_st.lanes = eff_lanes;
                    next_st.cs_sel = cpu_req.cs_sel;
                    next_st.phase = cpu_req.write ? xbp_pkg::XBP_WRITE : xbp_pkg::XBP_READ;
                end
            end
            xbp_pkg::XBP_READ: begin
                if (!wait_in) begin
                    next_st.rdata = data_in & lane_mask;
                    next_st.done = 1'b1;
                    next_st.phase = xbp_pkg::XBP_IDLE;
                end
            end
            xbp_pkg::XBP_WRITE: begin
                if (!wait_in) begin
                    next_st.done = 1'b1;
                    next_st.phase = xbp_pkg::XBP_IDLE;
                end
            end
            default: next_st.phase = xbp_pkg::XBP_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.phase <= xbp_pkg::XBP_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign lane_mask = {{8{st.lanes[1]}}, {8{st.lanes[0]}}};

    // Processor handshake
    assign cpu_stall = active;
    assign cpu_done = st.done;
    assign cpu_rdata = st.rdata;

    // Address: zero when idle or internal, output only on selected pins
    assign addr_out = (active && !exec_internal) ? st.addr : 24'h000000;
    assign addr_oe = enabled ? addr_af : 24'h000000;

    // Data drivers only during writes on selected active lanes
    assign data_out = st.wdata & lane_mask;
    assign data_oe = (enabled && st.phase == xbp_pkg::XBP_WRITE) ?
        (data_af & lane_mask) : 16'h0000;

    // Strobes, one-hot phase keeps them exclusive
    assign read_strobe = st.phase == xbp_pkg::XBP_READ;
    assign write_strobe = st.phase == xbp_pkg::XBP_WRITE;
    assign upper_byte_enable = active && st.lanes[1];
    assign lower_byte_enable = active && st.lanes[0];

    // Chip select with per-line polarity, 1 in cs_pol means active high
    always_comb begin
        cs_raw = 6'h00;
        if (active && st.cs_sel < 3'(xbp_pkg::NUM_CS)) begin
            cs_raw[st.cs_sel] = 1'b1;
        end
    end
    assign chip_select_out = ~(cs_raw ^ cs_pol);
    assign chip_select_oe = enabled ? 6'h3f : 6'h00;

    // Checks
    property p_excl;
        @(posedge aclk) disable iff (!aresetn) !(read_strobe && write_strobe);
    endproperty
    a_excl: assert property (p_excl) else $error("both strobes high");
    property p_addr_stable;
        @(posedge aclk) disable iff (!aresetn)
            (read_strobe && $past(read_strobe)) |-> $stable(addr_out);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved");
    property p_internal_zero;
        @(posedge aclk) disable iff (!aresetn) exec_internal |-> addr_out == 24'h000000;
    endproperty
    a_internal_zero: assert property (p_internal_zero) else $error("address not zero");
    property p_no_drive_read;
        @(posedge aclk) disable iff (!aresetn) !write_strobe |-> data_oe == 16'h0000;
    endproperty
    a_no_drive_read: assert property (p_no_drive_read) else $error("data driven");
    property p_narrow;
        @(posedge aclk) disable iff (!aresetn)
            !wide && $rose(active) |-> !upper_byte_enable && data_oe[15:8] == 8'h00;
    endproperty
    a_narrow: assert property (p_narrow) else $error("upper lane in 8-bit");
    property p_wait_hold;
        @(posedge aclk) disable iff (!aresetn) (active && wait_in) |=> active && !cpu_done;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait ignored");
    property p_read_end;
        @(posedge aclk) disable iff (!aresetn)
            (read_strobe && !wait_in) |=> !read_strobe && cpu_done;
    endproperty
    a_read_end: assert property (p_read_end) else $error("read did not end");
    property p_start;
        @(posedge aclk) disable iff (!aresetn)
            (!active && !cpu_done && cpu_req.req && enabled && !exec_internal && cpu_req.write)
            |=> write_strobe;
    endproperty
    a_start: assert property (p_start) else $error("write not started");
    property p_aoe;
        @(posedge aclk) disable iff (!aresetn) !enabled |-> addr_oe == 24'h000000;
    endproperty
    a_aoe: assert property (p_aoe) else $error("address driven while off");
    c_read: cover property (@(posedge aclk) disable iff (!aresetn) $fell(read_strobe));
    c_write: cover property (@(posedge aclk) disable iff (!aresetn) $fell(write_strobe));
    c_wait: cover property (@(posedge aclk) disable iff (!aresetn) active && wait_in ##1 active);
endmodule

// ==== verification/xbp_mem_model.sv ====
// Behavioural external memory that answers the block's bus strobes
`timescale 1ns/1ps
module xbp_mem_model (
    // Clock
    input wire logic aclk,
    // Bus from the block
    input wire logic [23:0] addr_out,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe,
    input wire logic read_strobe,
    input wire logic write_strobe,
    input wire logic upper_byte_enable,
    input wire logic lower_byte_enable,
    // Bench control and answers
    input wire logic [3:0] wait_cycles,
    output logic [15:0] data_in,
    output logic wait_in
);
    logic [15:0] mem [16];
    logic [15:0] last;
    logic [15:0] rd_word;
    logic [3:0] cnt;
    // Known start pattern
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'h5a00 + 16'(i);
        end
        last = 16'h0000;
        cnt = 4'h0;
    end
    assign rd_word = mem[addr_out[3:0]];
    // Stretch each strobe by the asked number of cycles
    assign wait_in = (read_strobe | write_strobe) && (cnt < wait_cycles);
    // Wire level; a released line shows the memory word during reads, else the inverse of the last read word
    assign data_in = (data_oe & data_out) | (~data_oe & (read_strobe ? rd_word : ~last));
    // Strobe counter, last driven word and lane-wise store
    always @(posedge aclk) begin
        cnt <= (read_strobe | write_strobe) ? cnt + 4'h1 : 4'h0;
        if (read_strobe) begin
            last <= rd_word;
        end
        if (write_strobe && !wait_in) begin
            if (upper_byte_enable) begin
                mem[addr_out[3:0]][15:8] <= data_in[15:8];
            end
            if (lower_byte_enable) begin
                mem[addr_out[3:0]][7:0] <= data_in[7:0];
            end
        end
    end
endmodule

// ==== verification/tb_xbp_ext_bus.sv ====
// Self-checking bench for the external bus pin block
`timescale 1ns/1ps
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_xbp_ext_bus;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, cpu_stall, cpu_done, exec_internal;
    logic read_strobe, write_strobe, upper_byte_enable, lower_byte_enable, wait_in;
    logic mon_seen;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, wait_cycles;
    logic [1:0] bresp, rresp, mon_be, mon_kind;
    logic [23:0] addr_out, addr_oe, mon_addr;
    logic [15:0] cpu_rdata, data_in, data_out, data_oe, mon_oe;
    logic [5:0] chip_select_out, chip_select_oe, mon_cs;
    xbp_pkg::xbp_req_t cpu_req;
    int num_errors = 0;
    int cmp_count = 0;
    int strobes = 0;

    xbp_ext_bus u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cpu_req(cpu_req), .cpu_stall(cpu_stall), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata),
        .exec_internal(exec_internal), .addr_out(addr_out), .addr_oe(addr_oe),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .read_strobe(read_strobe),
        .write_strobe(write_strobe), .chip_select_out(chip_select_out),
        .chip_select_oe(chip_select_oe), .upper_byte_enable(upper_byte_enable),
        .lower_byte_enable(lower_byte_enable), .wait_in(wait_in));
    xbp_mem_model u_mem (.aclk(aclk), .addr_out(addr_out), .data_out(data_out),
        .data_oe(data_oe), .read_strobe(read_strobe), .write_strobe(write_strobe),
        .upper_byte_enable(upper_byte_enable), .lower_byte_enable(lower_byte_enable),
        .wait_cycles(wait_cycles), .data_in(data_in), .wait_in(wait_in));

    // 40 MHz clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // Pin snapshot during strobes, with per-cycle pin checks
    always @(negedge aclk) begin
        if (aresetn) begin
            `CHECK(read_strobe & write_strobe, 1'b0)
            `CHECK(write_strobe ? 16'h0000 : data_oe, 16'h0000)
            `CHECK(cpu_stall, read_strobe | write_strobe)
            if (exec_internal) `CHECK(addr_out, 24'h000000)
            if ((read_strobe | write_strobe) && mon_seen) `CHECK(addr_out, mon_addr)
            if (read_strobe | write_strobe) begin
                mon_seen = 1'b1;
                mon_addr = addr_out;
                mon_cs = chip_select_out;
                mon_oe = mon_oe | data_oe;
                mon_be = {upper_byte_enable, lower_byte_enable};
                mon_kind = mon_kind | {read_strobe, write_strobe};
                strobes++;
            end
        end
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Register write with an OKAY answer expected
    task automatic reg_set(input logic [7:0] a, input logic [31:0] d);
        logic aw_hs, w_hs, b_hs;
        b_hs = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_hs) begin
            @(negedge aclk);
            aw_hs = awvalid & awready;
            w_hs = wvalid & wready;
            b_hs = bvalid & bready;
            if (b_hs) `CHECK(bresp, xbp_pkg::RESP_OKAY)
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_hs) bready <= 1'b0;
        end
    endtask

    task automatic reg_get(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        r_hs = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_hs) begin
            @(negedge aclk);
            ar_hs = arvalid & arready;
            r_hs = rvalid & rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_hs) rready <= 1'b0;
        end
    endtask

    // One processor access; held until done or the limit runs out
    task automatic cpu_access(input logic wr, input logic [23:0] a, input logic [15:0] d,
        input logic [1:0] ln, input logic [2:0] cs, input int lim, output logic ok,
        output int cyc);
        ok = 1'b0;
        cyc = 0;
        mon_seen = 1'b0;
        mon_oe = 16'h0000;
        mon_kind = 2'b00;
        @(posedge aclk);
        cpu_req <= '{req: 1'b1, write: wr, addr: a, wdata: d, lanes: ln, cs_sel: cs};
        while (!ok && cyc < lim) begin
            @(negedge aclk);
            cyc++;
            ok = cpu_done;
        end
        // Release just after the edge at which done is sampled
        @(posedge aclk);
        cpu_req.req <= 1'b0;
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 5; i++) begin
            reg_get(8'(i * 4), d, r);
            `CHECK({r, d}, 34'h0)
        end
        reg_get(8'h14, d, r);
        `CHECK({r, d}, {xbp_pkg::RESP_SLVERR, 32'h0})
        reg_set(xbp_pkg::OFF_CS_POL, 32'hffffffff);
        reg_get(xbp_pkg::OFF_CS_POL, d, r);
        `CHECK(d, 32'h0000003f)
    endtask

    task automatic t_off_and_internal();
        logic ok;
        int cyc;
        int s0;
        s0 = strobes;
        cpu_access(1'b1, 24'h000001, 16'h1111, 2'h3, 3'h0, 8, ok, cyc);
        `CHECK({ok, addr_oe, data_oe, chip_select_oe}, 47'h0)
        reg_set(xbp_pkg::OFF_CTRL, 32'h3);
        @(posedge aclk);
        exec_internal <= 1'b1;
        cpu_access(1'b0, 24'h00abcd, 16'h0000, 2'h3, 3'h0, 8, ok, cyc);
        `CHECK({ok, mon_seen}, 2'b00)
        `CHECK(strobes - s0, 0)
        @(posedge aclk);
        exec_internal <= 1'b0;
    endtask

    task automatic t_rw16();
        logic ok;
        int cyc;
        reg_set(xbp_pkg::OFF_ADDR_AF, 32'h0000ffff);
        reg_set(xbp_pkg::OFF_DATA_AF, 32'h0000ffff);
        `CHECK(addr_oe, 24'h00ffff)
        cpu_access(1'b1, 24'h000005, 16'h1234, 2'h3, 3'h0, 20, ok, cyc);
        `CHECK({ok, mon_kind, mon_oe, mon_addr}, {3'b101, 16'hffff, 24'h000005})
        cpu_access(1'b0, 24'h000005, 16'h0000, 2'h3, 3'h0, 20, ok, cyc);
        `CHECK({ok, mon_kind, mon_oe, cpu_rdata}, {3'b110, 16'h0, 16'h1234})
        reg_set(xbp_pkg::OFF_DATA_AF, 32'h00000f0f);
        cpu_access(1'b1, 24'h000009, 16'hffff, 2'h3, 3'h0, 20, ok, cyc);
        `CHECK(mon_oe, 16'h0f0f)
        reg_set(xbp_pkg::OFF_DATA_AF, 32'h0000ffff);
    endtask

    task automatic t_width8_and_wait();
        logic ok;
        int c0, c3;
        reg_set(xbp_pkg::OFF_CTRL, 32'h1);
        cpu_access(1'b1, 24'h000006, 16'habcd, 2'h3, 3'h0, 20, ok, c0);
        `CHECK({ok, mon_be, mon_oe}, {3'b101, 16'h00ff})
        cpu_access(1'b0, 24'h000006, 16'h0000, 2'h3, 3'h0, 20, ok, c0);
        `CHECK({ok, mon_be, cpu_rdata}, {3'b101, 16'h00cd})
        reg_set(xbp_pkg::OFF_CTRL, 32'h3);
        cpu_access(1'b0, 24'h000006, 16'h0000, 2'h3, 3'h0, 20, ok, c0);
        `CHECK({ok, mon_be, cpu_rdata}, {3'b111, 16'h5acd})
        wait_cycles <= 4'h3;
        cpu_access(1'b0, 24'h000006, 16'h0000, 2'h3, 3'h0, 30, ok, c3);
        wait_cycles <= 4'h0;
        `CHECK({ok, cpu_rdata}, {1'b1, 16'h5acd})
        `CHECK(c3 - c0, 3)
    endtask

    task automatic t_cs();
        logic ok;
        int cyc;
        reg_set(xbp_pkg::OFF_CS_POL, 32'h05);
        for (int i = 0; i < 7; i++) begin
            cpu_access(1'b0, 24'h000000, 16'h0000, 2'h3, 3'(i), 20, ok, cyc);
            `CHECK({ok, mon_cs}, {1'b1, ~6'h05 ^ ((i < 6) ? 6'h01 << i : 6'h00)})
        end
        `CHECK(chip_select_oe, 6'h3f)
    endtask

    // Reset, then the scenarios in turn
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, exec_internal} = 7'h0;
        {awaddr, araddr, wdata, wait_cycles, cpu_req, mon_seen} = '0;
        wstrb = 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_off_and_internal();
        t_rw16();
        t_width8_and_wait();
        t_cs();
        wrap_up();
    end

    // Hang guard, far beyond the run's roughly 150 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        wrap_up();
    end
endmodule
